/* pcg_defs.svh */
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

`define PCG_PINS 8
// register byte offsets
`define PCG_OFS_PCR0 8'h00
`define PCG_OFS_STATUS 8'h20
`define PCG_OFS_IEN 8'h24
`define PCG_OFS_DMASEL 8'h28
`define PCG_OFS_DFLEN 8'h2C
`define PCG_OFS_PDOR 8'h40
`define PCG_OFS_PSOR 8'h44
`define PCG_OFS_PCOR 8'h48
`define PCG_OFS_PTOR 8'h4C
`define PCG_OFS_PDIR 8'h50
`define PCG_OFS_PDDR 8'h54
// pin control register fields
`define PCG_PCR_PS 0
`define PCG_PCR_PE 1
`define PCG_PCR_PFE 4
`define PCG_PCR_DFE 5
`define PCG_PCR_DSE 6
`define PCG_PCR_ODE 7
`define PCG_PCR_MUX_LO 8
`define PCG_PCR_MUX_HI 10
`define PCG_PCR_IRQC_LO 16
`define PCG_PCR_IRQC_HI 18
// reset values
`define PCG_MUX_RST 24'h000000
`define PCG_DFLEN_RST 4'h3
// fast port selects
`define PCG_FA_PDOR 2'h0
`define PCG_FA_PDDR 2'h1
`define PCG_FA_PDIR 2'h2
`endif

/* pcg_pkg.sv */
package pcg_pkg;
	typedef enum logic [2:0] {
		PCG_IRQ_OFF = 3'h0,
		PCG_IRQ_RISE = 3'h1,
		PCG_IRQ_FALL = 3'h2,
		PCG_IRQ_BOTH = 3'h3,
		PCG_IRQ_LOW = 3'h4,
		PCG_IRQ_HIGH = 3'h5
	} pcg_irqc_t;

	typedef struct packed {
		logic pe; // pull enable
		logic ps; // 1 pull-up, 0 pull-down
		logic dse; // high drive strength
		logic pfe; // passive filter enable
	} pcg_pad_t;

	typedef struct packed {
		pcg_irqc_t irqc;
		logic [2:0] mux;
		logic ode;
		logic dfe;
		pcg_pad_t pad;
	} pcg_pcr_t;
endpackage

/* pcg_port.sv */
// Added by the designer: the register addresses and the strobed register port.
`include "pcg_defs.svh"
module pcg_port #(
	parameter logic [23:0] MUX_RESET = `PCG_MUX_RST // 3 bits per pin
) (
	input wire logic clk, // bus clock
	input wire logic rst_n, // async reset
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic we, // write strobe
	input wire logic re, // read strobe
	output logic [31:0] rdata, // read data, cycle after re
	input wire logic [1:0] fa_sel, // fast port register select
	input wire logic fa_we, // fast port write
	input wire logic [7:0] fa_wdata, // fast port write data
	output logic [7:0] fa_rdata, // fast port read data, same cycle
	input wire logic [7:0] pin_in, // pad input levels
	output logic [7:0] pin_out, // pad output levels
	output logic [7:0] pin_oe, // pad output enables
	output pcg_pkg::pcg_pad_t [7:0] pad_cfg, // pull, drive, passive filter
	input wire logic [7:0][7:0] periph_out, // peripheral outputs per mux setting
	input wire logic [7:0][7:0] periph_oe, // peripheral enables per mux setting
	output logic [7:0] periph_in, // synchronised pin level, filtered only when dfe is set, to peripherals
	input wire logic dma_ack, // dma done, clears dma-routed flags
	output logic dma_req, // dma request level
	output logic irq, // interrupt level
	output logic wake // asynchronous wake request
);
	localparam int N = `PCG_PINS;

	pcg_pkg::pcg_pcr_t pcr [N];
	logic [7:0] status;
	logic [7:0] ien;
	logic [7:0] dma_sel;
	logic [3:0] dflen;
	logic [7:0] pdor;
	logic [7:0] pddr;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [7:0] filt;
	logic [3:0] fcnt [N];
	logic [7:0] prev;
	logic [7:0] level;
	logic [7:0] pdir;
	logic [7:0] evt;
	logic [7:0] next_pdor;
	logic [7:0] next_status;
	logic [31:0] next_rdata;

	function automatic logic pin_event(input pcg_pkg::pcg_irqc_t t, input logic v, input logic p);
		case (t)
			pcg_pkg::PCG_IRQ_RISE: pin_event = v & ~p;
			pcg_pkg::PCG_IRQ_FALL: pin_event = ~v & p;
			pcg_pkg::PCG_IRQ_BOTH: pin_event = v ^ p;
			pcg_pkg::PCG_IRQ_LOW: pin_event = ~v;
			pcg_pkg::PCG_IRQ_HIGH: pin_event = v;
			default: pin_event = 1'b0;
		endcase
	endfunction

	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = we && (addr == ofs);
	endfunction

	function automatic logic [31:0] pcr_word(input pcg_pkg::pcg_pcr_t p);
		logic [31:0] w;
		w = 32'h00000000;
		w[`PCG_PCR_PS] = p.pad.ps;
		w[`PCG_PCR_PE] = p.pad.pe;
		w[`PCG_PCR_PFE] = p.pad.pfe;
		w[`PCG_PCR_DFE] = p.dfe;
		w[`PCG_PCR_DSE] = p.pad.dse;
		w[`PCG_PCR_ODE] = p.ode;
		w[`PCG_PCR_MUX_HI:`PCG_PCR_MUX_LO] = p.mux;
		w[`PCG_PCR_IRQC_HI:`PCG_PCR_IRQC_LO] = p.irqc;
		pcr_word = w;
	endfunction

	// pin control registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < N; i++)
			begin
				pcr[i] <= '0;
				pcr[i].mux <= MUX_RESET[3 * i +: 3];
			end
		end
		else
		begin
			for (int i = 0; i < N; i++)
			begin
				if (wr_hit(8'(`PCG_OFS_PCR0 + 4 * i)))
				begin
					pcr[i].pad.ps <= wdata[`PCG_PCR_PS];
					pcr[i].pad.pe <= wdata[`PCG_PCR_PE];
					pcr[i].pad.pfe <= wdata[`PCG_PCR_PFE];
					pcr[i].dfe <= wdata[`PCG_PCR_DFE];
					pcr[i].pad.dse <= wdata[`PCG_PCR_DSE];
					pcr[i].ode <= wdata[`PCG_PCR_ODE];
					pcr[i].mux <= wdata[`PCG_PCR_MUX_HI:`PCG_PCR_MUX_LO];
					pcr[i].irqc <= pcg_pkg::pcg_irqc_t'(wdata[`PCG_PCR_IRQC_HI:`PCG_PCR_IRQC_LO]);
				end
			end
		end
	end

	// selected function per pin
	logic [2:0] mux [N];

	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			mux[i] = pcr[i].mux;
		end
	end

	// interrupt, dma and filter control registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ien <= 8'h00;
			dma_sel <= 8'h00;
			dflen <= `PCG_DFLEN_RST;
		end
		else
		begin
			if (wr_hit(`PCG_OFS_IEN))
			begin
				ien <= wdata[7:0];
			end
			if (wr_hit(`PCG_OFS_DMASEL))
			begin
				dma_sel <= wdata[7:0];
			end
			if (wr_hit(`PCG_OFS_DFLEN))
			begin
				dflen <= wdata[3:0];
			end
		end
	end

	// output data with set/clear/toggle; fast write lands last
	always_comb
	begin
		next_pdor = pdor;
		if (wr_hit(`PCG_OFS_PDOR))
		begin
			next_pdor = wdata[7:0];
		end
		if (wr_hit(`PCG_OFS_PSOR))
		begin
			next_pdor = pdor | wdata[7:0];
		end
		if (wr_hit(`PCG_OFS_PCOR))
		begin
			next_pdor = pdor & ~wdata[7:0];
		end
		if (wr_hit(`PCG_OFS_PTOR))
		begin
			next_pdor = pdor ^ wdata[7:0];
		end
		if (fa_we && fa_sel == `PCG_FA_PDOR)
		begin
			next_pdor = fa_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pdor <= 8'h00;
		end
		else
		begin
			pdor <= next_pdor;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pddr <= 8'h00;
		end
		else if (fa_we && fa_sel == `PCG_FA_PDDR)
		begin
			pddr <= fa_wdata;
		end
		else if (wr_hit(`PCG_OFS_PDDR))
		begin
			pddr <= wdata[7:0];
		end
	end

	// pin input synchroniser
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end
		else
		begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// digital filter: level accepted after dflen+1 stable cycles
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt <= 8'h00;
			for (int i = 0; i < N; i++)
			begin
				fcnt[i] <= 4'h0;
			end
		end
		else
		begin
			for (int i = 0; i < N; i++)
			begin
				if (pin_sync[i] == filt[i])
				begin
					fcnt[i] <= 4'h0;
				end
				else if (fcnt[i] >= dflen)
				begin
					filt[i] <= pin_sync[i];
					fcnt[i] <= 4'h0;
				end
				else
				begin
					fcnt[i] <= fcnt[i] + 4'h1;
				end
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			level[i] = pcr[i].dfe ? filt[i] : pin_sync[i];
			pdir[i] = (mux[i] != 3'h0) & level[i];
			periph_in[i] = (mux[i] >= 3'h2) & level[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev <= 8'h00;
		end
		else
		begin
			prev <= level;
		end
	end

	// event detection and sticky flags, set beats clear
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			evt[i] = (mux[i] != 3'h0) & pin_event(pcr[i].irqc, level[i], prev[i]);
		end
		next_status = status;
		if (wr_hit(`PCG_OFS_STATUS))
		begin
			next_status = next_status & ~wdata[7:0];
		end
		if (dma_ack)
		begin
			next_status = next_status & ~dma_sel;
		end
		next_status = next_status | evt;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status <= 8'h00;
		end
		else
		begin
			status <= next_status;
		end
	end

	assign irq = |(status & ien & ~dma_sel);
	assign dma_req = |(status & ien & dma_sel);

	// wake is combinational from the raw pad, so it works with clk stopped
	always_comb
	begin
		wake = 1'b0;
		for (int i = 0; i < N; i++)
		begin
			if (ien[i] && mux[i] != 3'h0)
			begin
				wake = wake | pin_event(pcr[i].irqc, pin_in[i], prev[i]);
			end
		end
	end

	// pad drive
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			logic o;
			logic e;
			o = 1'b0;
			e = 1'b0;
			if (mux[i] == 3'h1)
			begin
				o = pdor[i];
				e = pddr[i];
			end
			else if (mux[i] >= 3'h2)
			begin
				o = periph_out[i][mux[i]];
				e = periph_oe[i][mux[i]];
			end
			if (pcr[i].ode)
			begin
				e = e & ~o;
				o = 1'b0;
			end
			pin_out[i] = o;
			pin_oe[i] = e;
			pad_cfg[i] = pcr[i].pad;
		end
	end

	// fast port read
	always_comb
	begin
		case (fa_sel)
			`PCG_FA_PDOR: fa_rdata = pdor;
			`PCG_FA_PDDR: fa_rdata = pddr;
			`PCG_FA_PDIR: fa_rdata = pdir;
			default: fa_rdata = 8'h00;
		endcase
	end

	// bus read
	always_comb
	begin
		next_rdata = 32'h00000000;
		case (addr)
			`PCG_OFS_STATUS: next_rdata = {24'h000000, status};
			`PCG_OFS_IEN: next_rdata = {24'h000000, ien};
			`PCG_OFS_DMASEL: next_rdata = {24'h000000, dma_sel};
			`PCG_OFS_DFLEN: next_rdata = {28'h0000000, dflen};
			`PCG_OFS_PDOR: next_rdata = {24'h000000, pdor};
			`PCG_OFS_PDIR: next_rdata = {24'h000000, pdir};
			`PCG_OFS_PDDR: next_rdata = {24'h000000, pddr};
			default:
			begin
				for (int i = 0; i < N; i++)
				begin
					if (addr == 8'(`PCG_OFS_PCR0 + 4 * i))
					begin
						next_rdata = pcr_word(pcr[i]);
						next_rdata[`PCG_PCR_MUX_HI:`PCG_PCR_MUX_LO] = mux[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata <= 32'h00000000;
		end
		else if (re)
		begin
			rdata <= next_rdata;
		end
		else
		begin
			rdata <= 32'h00000000;
		end
	end
endmodule

/* pcg_port_properties.sv */
module pcg_port_props (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic [7:0] addr, // address
	input wire logic [31:0] wdata, // write data
	input wire logic we, // write strobe
	input wire logic [1:0] fa_sel, // fast select
	input wire logic fa_we, // fast write
	input wire logic [7:0] fa_wdata, // fast data
	input wire logic [7:0] fa_rdata, // fast read
	input wire logic [7:0] pin_oe, // pad enables
	input wire logic dma_ack, // dma done
	input wire logic dma_req, // dma request
	input wire logic irq // interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] wlo;
	assign wlo = wdata[7:0];
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_bus_wr(logic [7:0] a);
		we && addr == a && !fa_we && fa_sel == 2'h0 ##1 fa_sel == 2'h0;
	endsequence
	sequence s_fast_wr(logic [1:0] s);
		fa_we && fa_sel == s ##1 fa_sel == s;
	endsequence
	a_reset_no_drive: assert property (!$past(rst_n) |-> pin_oe == 8'h00)
		else $error("pin driven after reset");
	a_data_write: assert property (s_bus_wr(8'h40) |-> fa_rdata == $past(wlo))
		else $error("output data write lost");
	a_set_bits: assert property (s_bus_wr(8'h44) |-> fa_rdata == ($past(fa_rdata) | $past(wlo)))
		else $error("set alias wrong");
	a_clear_bits: assert property (s_bus_wr(8'h48) |-> fa_rdata == ($past(fa_rdata) & ~$past(wlo)))
		else $error("clear alias wrong");
	a_toggle_bits: assert property (s_bus_wr(8'h4C) |-> fa_rdata == ($past(fa_rdata) ^ $past(wlo)))
		else $error("toggle alias wrong");
	a_fast_data: assert property (s_fast_wr(2'h0) |-> fa_rdata == $past(fa_wdata))
		else $error("fast data write lost");
	a_fast_dir: assert property (s_fast_wr(2'h1) |-> fa_rdata == $past(fa_wdata))
		else $error("fast direction write lost");
	a_irq_sticky: assert property ($fell(irq) |-> $past(we))
		else $error("irq dropped without write");
	a_dma_sticky: assert property ($fell(dma_req) |-> $past(we) || $past(dma_ack))
		else $error("dma request dropped");
endmodule
bind pcg_port pcg_port_props pcg_port_props_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .we(we),
	.fa_sel(fa_sel), .fa_we(fa_we), .fa_wdata(fa_wdata), .fa_rdata(fa_rdata), .pin_oe(pin_oe),
	.dma_ack(dma_ack), .dma_req(dma_req), .irq(irq));

/* pcg_pins_model.sv */
module pcg_pins_model (
	input wire logic [7:0] pin_out, // pad level
	input wire logic [7:0] pin_oe, // pad enable
	input wire pcg_pkg::pcg_pad_t [7:0] pad_cfg, // pad settings
	input wire logic [7:0] ext_lvl, // far level
	input wire logic [7:0] ext_en, // far drives
	output logic [7:0] pin_in // resolved level
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin_in = 8'h00;
	always @(pin_out or pin_oe or pad_cfg or ext_lvl or ext_en)
		for (int i = 0; i < 8; i++)
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_lvl[i];
			else if (pad_cfg[i].pe)
				pin_in[i] = pad_cfg[i].ps;
			else
				pin_in[i] = ~pin_in[i]; // floating line
endmodule

/* tb.sv */
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [1:0] fa_sel = 2'h0;
	logic fa_we = 1'b0;
	logic [7:0] fa_wdata = 8'h00;
	logic [7:0][7:0] periph_out = '0;
	logic [7:0][7:0] periph_oe = '0;
	logic dma_ack = 1'b0;
	logic [7:0] ext_lvl = 8'h00;
	logic [7:0] ext_en = 8'h00;
	logic [31:0] rdata;
	logic [7:0] fa_rdata, pin_in, pin_out, pin_oe, periph_in;
	pcg_pkg::pcg_pad_t [7:0] pad_cfg;
	logic dma_req, irq, wake;
	logic [2:0] irq_ty [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
	logic [4:0] irq_st = 5'b01010;
	int num_errors = 0;
	int tests_run = 0;
	pcg_port pcg_port_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
		.fa_sel(fa_sel), .fa_we(fa_we), .fa_wdata(fa_wdata), .fa_rdata(fa_rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pad_cfg(pad_cfg), .periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .dma_ack(dma_ack), .dma_req(dma_req), .irq(irq), .wake(wake));
	pcg_pins_model pcg_pins_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pad_cfg(pad_cfg),
		.ext_lvl(ext_lvl), .ext_en(ext_en), .pin_in(pin_in));
	initial
	begin
		forever #25 clk = ~clk;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
		wt(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		wt(1);
		`CHK(rdata, e)
	endtask
	task automatic fw(input logic [1:0] s, input logic [7:0] d);
		@(posedge clk);
		fa_we <= 1'b1;
		fa_sel <= s;
		fa_wdata <= d;
		@(posedge clk);
		fa_we <= 1'b0;
		wt(1);
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2000) @(posedge clk);
		num_errors++;
		final_report();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h54, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h2C, 32'h3);
		rd(8'h60, 32'h0);
		for (int i = 0; i < 8; i++)
			wr(8'(4 * i), 32'h100);
		wr(8'h54, 32'hFF);
		wr(8'h40, 32'hA5);
		`CHK({pin_oe, pin_out}, 16'hFFA5)
		wt(4);
		rd(8'h50, 32'hA5);
		wr(8'h44, 32'h0A);
		wr(8'h48, 32'h05);
		wr(8'h4C, 32'hFF);
		rd(8'h40, 32'h55);
		fw(2'h0, 8'h3C);
		`CHK({fa_rdata, pin_out}, 16'h3C3C)
		@(posedge clk);
		fa_sel <= 2'h2;
		wt(4);
		`CHK(fa_rdata, 8'h3C)
		$display("test gpio done");
		wr(8'h00, 32'h180);
		`CHK({pin_oe[0], pin_out[0]}, 2'b10)
		wr(8'h44, 32'h01);
		`CHK(pin_oe[0], 1'b0)
		@(posedge clk);
		periph_oe[1][2] <= 1'b1;
		periph_out[1][2] <= 1'b1;
		wr(8'h04, 32'h253);
		`CHK(pad_cfg[1], 4'hF)
		`CHK({pin_oe[1], pin_out[1]}, 2'b11)
		rd(8'h04, 32'h253);
		wt(4);
		`CHK(periph_in[1], 1'b1)
		$display("test pad done");
		fw(2'h1, 8'hFB);
		fw(2'h2, 8'h00);
		rd(8'h54, 32'hFB);
		rd(8'h40, 32'h3D);
		ext_en[2] <= 1'b1;
		wr(8'h24, 32'h4);
		for (int k = 0; k < 5; k++)
		begin
			@(posedge clk);
			ext_lvl[2] <= irq_st[k];
			wt(4);
			wr(8'h08, {13'h0, irq_ty[k], 16'h100});
			wr(8'h20, 32'hFF);
			@(posedge clk);
			ext_lvl[2] <= ~irq_st[k];
			wt(6);
			`CHK(irq, 1'b1)
			if (k > 2)
				`CHK(wake, 1'b1)
			wr(8'h08, 32'h100);
			wr(8'h20, 32'hFB);
			rd(8'h20, 32'h4);
			@(posedge clk);
			ext_lvl[2] <= irq_st[k];
			wt(4);
			wr(8'h20, 32'h4);
			`CHK(irq, 1'b0)
		end
		$display("test irq done");
		wr(8'h08, 32'h50100);
		@(posedge clk);
		ext_lvl[2] <= 1'b1;
		wt(6);
		wr(8'h24, 32'h0);
		`CHK(irq, 1'b0)
		wr(8'h24, 32'h4);
		wr(8'h28, 32'h4);
		`CHK({dma_req, irq}, 2'b10)
		wr(8'h08, 32'h100);
		@(posedge clk);
		dma_ack <= 1'b1;
		@(posedge clk);
		dma_ack <= 1'b0;
		wt(1);
		`CHK(dma_req, 1'b0)
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h54, 32'h0);
		$display("test dma done");
		wr(8'h08, 32'h120);
		wt(4);
		@(posedge clk);
		fa_sel <= 2'h2;
		ext_lvl[2] <= 1'b0;
		wt(5);
		`CHK(fa_rdata[2], 1'b1)
		wt(3);
		`CHK(fa_rdata[2], 1'b0)
		$display("test filter done");
		final_report();
	end
endmodule
